/* tb_top.sv */
// tb_top: self-checking bench for tpc_panel_config
// assumes: 100 MHz clock, inputs driven 1 ns after rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_srst = 1, i_wr_en = 0, i_setup_one_cmd = 0, i_pal_wr_en = 0, i_pix_valid = 0, stall = 0;
  logic [7:0] i_wr_addr = 0, i_wr_data = 0, i_setup_one_param = 0, i_rd_addr = 0, o_rd_data;
  logic [3:0] i_pal_wr_index = 0, i_pix_data = 0, o_rs, o_vm;
  logic [5:0] i_pal_wr_data = 0, o_lines;
  logic [1:0] i_bpp = 0;
  logic [2:0] act = 0;
  logic [4:0] o_mult, o_band;
  logic o_pix_ready, o_ready, o_valid, o_ls, o_fs, o_de, o_edge, o_near, o_en;
  int num_errors = 0, num_checks = 0, cyc = 0;
  tpc_panel_config dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_setup_one_cmd(i_setup_one_cmd), .i_setup_one_param(i_setup_one_param),
    .i_pal_wr_en(i_pal_wr_en), .i_pal_wr_index(i_pal_wr_index), .i_pal_wr_data(i_pal_wr_data),
    .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .i_bpp(i_bpp), .i_pix_valid(i_pix_valid),
    .i_pix_data(i_pix_data), .i_line_active(act[1]), .i_frame_active(act[2]), .i_de_active(act[0]),
    .o_pix_ready(o_pix_ready), .i_panel_ready(o_ready), .o_panel_valid(o_valid), .o_panel_pixel_lines(o_lines),
    .o_panel_line_sync(o_ls), .o_panel_frame_sync(o_fs), .o_panel_data_enable(o_de),
    .o_pll_range_select(o_rs), .o_pll_multiplier(o_mult), .o_vco_multiplier(o_vm), .o_vco_band_select(o_band),
    .o_shift_falling_edge(o_edge), .o_nearest_upscale(o_near), .o_panel_enable(o_en));
  tpc_panel_sink sink (.i_clk(i_clk), .i_stall(stall), .i_valid(o_valid), .i_data({o_fs, o_ls, o_de, o_lines}),
    .o_ready(o_ready));
  initial forever #5 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {i_wr_en, i_wr_addr, i_wr_data} = {1'b1, a, d};
    @(posedge i_clk); #1 i_wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_rd_addr = a;
    @(posedge i_clk); #1 chk(o_rd_data, exp);
  endtask
  task automatic setup(input logic [7:0] p);
    {i_setup_one_cmd, i_setup_one_param} = {1'b1, p};
    @(posedge i_clk); #1 i_setup_one_cmd = 0;
  endtask
  task automatic send(input logic [1:0] b, input logic [3:0] p, input logic [2:0] s);
    int n;
    {i_bpp, i_pix_data, act, i_pix_valid} = {b, p, s, 1'b1};
    n = 0;
    do @(negedge i_clk); while (o_pix_ready !== 1'b1 && n++ < 50);
    if (n >= 50) chk(o_pix_ready, 1'b1);
    // valid stays up so back-to-back sends never toggle it within one step
    @(posedge i_clk); #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h32, 8'h99); rd(8'h33, 8'h00); rd(8'h34, 8'h00);
    chk(o_pix_ready, 1'b0);
    wr(8'h32, 8'h70); chk(o_mult, 5'h01); rd(8'h32, 8'h70);
    wr(8'h32, 8'h9f); chk(o_mult, 5'h10); chk(o_rs, 4'h9);
    for (int c = 0; c < 4; c++) begin
      wr(8'h33, {1'b1, 2'(c), 5'h01});
      chk(o_vm, (c == 0) ? 4'h0 : 4'h1 << c); chk(o_band, 5'h01);
      rd(8'h33, {1'b0, 2'(c), 5'h01});
    end
    setup(8'hff); rd(8'h34, 8'hf7); chk({o_edge, o_near, o_en}, 3'b111);
    rd(8'h40, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_grey;
    setup(8'h01); stall = 1;
    send(2'h0, 4'h1, 3'b011); send(2'h1, 4'h1, 3'b011);
    @(negedge i_clk) chk(o_pix_ready, 1'b0);
    @(posedge i_clk); #1 stall = 0;
    send(2'h1, 4'h2, 3'b011); send(2'h2, 4'hd, 3'b011);
    i_pix_valid = 0;
    repeat (4) @(posedge i_clk); #1 chk(9'(sink.got.size()), 9'h004);
    foreach (sink.got[i]) chk(sink.got[i], {3'b100, 2'h0, i == 0 ? 4'hf : i == 1 ? 4'h5 : i == 2 ? 4'ha : 4'hd});
    sink.got.delete();
    $display("test grey done");
  endtask
  task automatic t_pal;
    {i_pal_wr_en, i_pal_wr_index, i_pal_wr_data} = {1'b1, 4'h2, 6'h2b};
    @(posedge i_clk); #1 i_pal_wr_en = 0;
    setup(8'he3); chk({o_edge, o_near}, 2'b00);
    send(2'h1, 4'h2, 3'b111);
    i_pix_valid = 0;
    repeat (3) @(posedge i_clk); #1 chk(9'(sink.got.size()), 9'h001);
    chk(sink.got[0], {3'b111, 6'h2b});
    $display("test palette done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) if (++cyc > 3000) begin
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_srst = 0;
    t_regs(); t_grey(); t_pal();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

/* tpc_buf_if.sv */
// tpc_buf_if: valid/ready word stream between the mapper and its two-entry buffer
// assumes: single clock domain
`timescale 1ns/1ps
`default_nettype none
interface tpc_buf_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

/* tpc_panel_config.sv */
// tpc_panel_config: pll parameter and panel interface registers, pixel-to-data-line mapper
// assumes: host writes parameter bytes on i_wr_* and reads on i_rd_addr; pll and timing live outside
//
// Function
// [RULE_01] host sets range by pll input frequency
// [RULE_02] multiplier is low nibble plus one
// [RULE_03] host keeps pll output 20 to 110 MHz
// [RULE_04] reserved bits stay zero on write
// [RULE_05] vco code 01/10/11 gives 2/4/8
// [RULE_06] host keeps vco 100 to 400 MHz
// [RULE_07] host sets vco band by frequency
// [RULE_08] sync and enable polarity from config bits
// [RULE_09] setup-one command loads config register
// [RULE_10] grey-scale uses four lines, upper two idle
// [RULE_11] grey-scale maps 1/2/4 bpp pixel patterns
// [RULE_12] bit 0 enables panel interface
// [RULE_13] palette mode outputs indexed six-bit entry
// [RULE_14] host keeps shift clock 2 to 35 MHz
// [RULE_15] bit 4 edge select, bit 1 colour mode
// [RULE_16] bit 2 selects up-scaling method
`timescale 1ns/1ps
`default_nettype none
module tpc_panel_config #(
  parameter int PAL_ENTRIES = 16
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_setup_one_cmd,
  input  wire logic [7:0] i_setup_one_param,
  input  wire logic       i_pal_wr_en,
  input  wire logic [3:0] i_pal_wr_index,
  input  wire logic [5:0] i_pal_wr_data,
  input  wire logic [7:0] i_rd_addr,
  output var  logic [7:0] o_rd_data,
  input  wire logic [1:0] i_bpp,
  input  wire logic       i_pix_valid,
  input  wire logic [3:0] i_pix_data,
  input  wire logic       i_line_active,
  input  wire logic       i_frame_active,
  input  wire logic       i_de_active,
  output var  logic       o_pix_ready,
  input  wire logic       i_panel_ready,
  output var  logic       o_panel_valid,
  output var  logic [5:0] o_panel_pixel_lines,
  output var  logic       o_panel_line_sync,
  output var  logic       o_panel_frame_sync,
  output var  logic       o_panel_data_enable,
  output var  logic [3:0] o_pll_range_select,
  output var  logic [4:0] o_pll_multiplier,
  output var  logic [3:0] o_vco_multiplier,
  output var  logic [4:0] o_vco_band_select,
  output var  logic       o_shift_falling_edge,
  output var  logic       o_nearest_upscale,
  output var  logic       o_panel_enable
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] range_mult_q, range_mult_d;
  logic [7:0] vco_band_q, vco_band_d;
  logic [7:0] cfg_q, cfg_d;
  logic [5:0] pal_q [PAL_ENTRIES];
  logic [5:0] pal_d [PAL_ENTRIES];
  logic [7:0] rd_q, rd_d;

  always_comb begin
    range_mult_d = range_mult_q;
    vco_band_d   = vco_band_q;
    cfg_d        = cfg_q;
    pal_d        = pal_q;
    if (i_wr_en && i_wr_addr == tpc_pkg::REG_PLL_RANGE_MULT) begin
      range_mult_d = i_wr_data;
    end
    if (i_wr_en && i_wr_addr == tpc_pkg::REG_PLL_VCO_BAND) begin
      vco_band_d = i_wr_data & tpc_pkg::VCO_WRITE_MASK; // see [RULE_04]
    end
    if (i_wr_en && i_wr_addr == tpc_pkg::REG_PANEL_CONFIG) begin
      cfg_d = i_wr_data & tpc_pkg::CFG_WRITE_MASK; // see [RULE_04]
    end
    if (i_setup_one_cmd) begin
      cfg_d = i_setup_one_param & tpc_pkg::CFG_WRITE_MASK; // see [RULE_09]
    end
    if (i_pal_wr_en && 32'(i_pal_wr_index) < PAL_ENTRIES) begin
      pal_d[i_pal_wr_index] = i_pal_wr_data;
    end
    unique case (i_rd_addr)
      tpc_pkg::REG_PLL_RANGE_MULT: rd_d = range_mult_q;
      tpc_pkg::REG_PLL_VCO_BAND:   rd_d = vco_band_q;
      tpc_pkg::REG_PANEL_CONFIG:   rd_d = cfg_q;
      default:                     rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      range_mult_q <= tpc_pkg::RST_PLL_RANGE_MULT;
      vco_band_q   <= tpc_pkg::RST_PLL_VCO_BAND;
      cfg_q        <= tpc_pkg::RST_PANEL_CONFIG;
      rd_q         <= 8'h00;
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        pal_q[i] <= tpc_pkg::RST_PALETTE_ENTRY[5:0];
      end
    end else begin
      range_mult_q <= range_mult_d;
      vco_band_q   <= vco_band_d;
      cfg_q        <= cfg_d;
      rd_q         <= rd_d;
      pal_q        <= pal_d;
    end
  end

  assign o_rd_data = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // pll decode
  function automatic logic [3:0] vco_mult(input logic [1:0] code);
    unique case (code)
      2'h1:    vco_mult = 4'h2;
      2'h2:    vco_mult = 4'h4;
      2'h3:    vco_mult = 4'h8;
      default: vco_mult = 4'h0; // reserved code
    endcase
  endfunction

  // range and band are passed straight to the pll; host picks them
  assign o_pll_range_select   = range_mult_q[tpc_pkg::RANGE_LSB +: 4]; // see [RULE_01]
  assign o_pll_multiplier     = {1'b0, range_mult_q[tpc_pkg::MULT_LSB +: 4]} + 5'h01; // see [RULE_02]
  assign o_vco_multiplier     = vco_mult(vco_band_q[tpc_pkg::VCO_DIV_LSB +: 2]); // see [RULE_05]
  assign o_vco_band_select    = vco_band_q[tpc_pkg::BAND_LSB +: 5]; // see [RULE_07]
  assign o_shift_falling_edge = cfg_q[tpc_pkg::CFG_SHIFT_EDGE]; // see [RULE_15]
  assign o_nearest_upscale    = cfg_q[tpc_pkg::CFG_NEAREST]; // see [RULE_16]
  assign o_panel_enable       = cfg_q[tpc_pkg::CFG_ENABLE]; // see [RULE_12]

  ////////////////////////////////////////////////////////////////////////////
  // pixel mapping
  function automatic logic [5:0] grey_map(input logic [1:0] bpp, input logic [3:0] pix);
    unique case (bpp)
      tpc_pkg::BPP_1: grey_map = {2'h0, {4{pix[0]}}};
      tpc_pkg::BPP_2: grey_map = {2'h0, {2{pix[1:0]}}};
      tpc_pkg::BPP_4: grey_map = {2'h0, pix};
      default:        grey_map = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] pal_index(input logic [1:0] bpp, input logic [3:0] pix);
    unique case (bpp)
      tpc_pkg::BPP_1: pal_index = {3'h0, pix[0]};
      tpc_pkg::BPP_2: pal_index = {2'h0, pix[1:0]};
      default:        pal_index = pix;
    endcase
  endfunction

  tpc_buf_if #(.W(9)) map_if ();
  logic [5:0] mapped;
  logic [8:0] out_word;
  logic [3:0] idx;

  always_comb begin
    idx = pal_index(i_bpp, i_pix_data);
    if (cfg_q[tpc_pkg::CFG_PALETTE]) begin
      mapped = (32'(idx) < PAL_ENTRIES) ? pal_q[idx] : 6'h00; // see [RULE_13]
    end else begin
      mapped = grey_map(i_bpp, i_pix_data); // see [RULE_10] [RULE_11]
    end
  end

  // polarity applied before buffering so syncs stay aligned with data
  assign map_if.valid = i_pix_valid && cfg_q[tpc_pkg::CFG_ENABLE]; // see [RULE_12]
  assign map_if.data  = {i_frame_active ^ ~cfg_q[tpc_pkg::CFG_FRAME_POL],
                         i_line_active ^ ~cfg_q[tpc_pkg::CFG_LINE_POL],
                         i_de_active ^ ~cfg_q[tpc_pkg::CFG_DE_POL],
                         mapped}; // see [RULE_08]
  assign o_pix_ready  = map_if.ready && cfg_q[tpc_pkg::CFG_ENABLE];

  tpc_skid_buffer #(.W(9)) u_buf (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .in_if   (map_if),
    .o_valid (o_panel_valid),
    .o_data  (out_word),
    .i_ready (i_panel_ready)
  );

  assign o_panel_frame_sync  = out_word[8];
  assign o_panel_line_sync   = out_word[7];
  assign o_panel_data_enable = out_word[6];
  assign o_panel_pixel_lines = out_word[5:0];
endmodule // tpc_panel_config
`default_nettype wire

/* tpc_panel_config_sva.sv */
// tpc_panel_config_sva: port-level checks for the panel config block
// assumes: bound onto tpc_panel_config, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module tpc_cfg_sva (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_setup_one_cmd,
  input wire logic [7:0] i_setup_one_param,
  input wire logic [7:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_pix_ready,
  input wire logic       i_panel_ready,
  input wire logic       o_panel_valid,
  input wire logic [5:0] o_panel_pixel_lines,
  input wire logic [4:0] o_pll_multiplier,
  input wire logic [3:0] o_vco_multiplier,
  input wire logic       o_panel_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_wr32;
    i_wr_en && i_wr_addr == 8'h32;
  endsequence
  sequence s_rd32;
    i_rd_addr == 8'h32 && !i_wr_en;
  endsequence
  a_reset_values: assert property ($fell(i_srst) |-> o_pll_multiplier == 5'h0a && !o_panel_valid)
    else $error("reset values wrong");
  a_mult_plus_one: assert property (s_wr32 |=> o_pll_multiplier == {1'b0, $past(i_wr_data[3:0])} + 5'h01)
    else $error("multiplier wrong");
  a_wr_readback: assert property (s_wr32 ##1 s_rd32 |=> o_rd_data == $past(i_wr_data, 2))
    else $error("readback wrong");
  a_vco_decode: assert property (i_wr_en && i_wr_addr == 8'h33 |=> o_vco_multiplier ==
    (($past(i_wr_data[6:5]) == 2'h0) ? 4'h0 : (4'h1 << $past(i_wr_data[6:5])))) else $error("vco decode wrong");
  a_vco_rsvd_zero: assert property (i_rd_addr == 8'h33 |=> !o_rd_data[7])
    else $error("vco reserved bit set");
  a_cfg_rsvd_zero: assert property (i_rd_addr == 8'h34 |=> !o_rd_data[3])
    else $error("config reserved bit set");
  a_unmapped_zero: assert property (i_rd_addr < 8'h32 || i_rd_addr > 8'h34 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_setup_loads: assert property (i_setup_one_cmd |=> o_panel_enable == $past(i_setup_one_param[0]))
    else $error("setup command not loaded");
  a_off_refuses: assert property (!o_panel_enable |-> !o_pix_ready)
    else $error("pixel taken while disabled");
  a_stall_holds: assert property (o_panel_valid && !i_panel_ready |=> o_panel_valid && $stable(o_panel_pixel_lines))
    else $error("word lost in stall");
endmodule // tpc_cfg_sva
bind tpc_panel_config tpc_cfg_sva sva (.*);
`default_nettype wire

/* tpc_panel_sink.sv */
// tpc_panel_sink: panel side model, collects {frame,line,de,lines} words
// assumes: stall input from bench, ready low while stalled
`timescale 1ns/1ps
`default_nettype none
module tpc_panel_sink (
  input  wire logic       i_clk,
  input  wire logic       i_stall,
  input  wire logic       i_valid,
  input  wire logic [8:0] i_data,
  output var  logic       o_ready
);
  logic [8:0] got [$];
  assign o_ready = !i_stall;
  always @(posedge i_clk) if (i_valid && o_ready) got.push_back(i_data);
endmodule // tpc_panel_sink
`default_nettype wire

/* tpc_pkg.sv */
// tpc_pkg: register offsets, reset values, field positions and modes for the panel config block
// assumes: one 100 MHz clock, byte-wide parameter writes
package tpc_pkg;
  localparam logic [7:0] REG_PLL_RANGE_MULT  = 8'h32;
  localparam logic [7:0] REG_PLL_VCO_BAND    = 8'h33;
  localparam logic [7:0] REG_PANEL_CONFIG    = 8'h34;
  localparam logic [7:0] RST_PLL_RANGE_MULT  = 8'h99;
  localparam logic [7:0] RST_PLL_VCO_BAND    = 8'h00;
  localparam logic [7:0] RST_PANEL_CONFIG    = 8'h00;
  localparam logic [7:0] RST_PALETTE_ENTRY   = 8'h00;
  localparam int         MULT_LSB            = 0;
  localparam int         RANGE_LSB           = 4;
  localparam int         BAND_LSB            = 0;
  localparam int         VCO_DIV_LSB         = 5;
  localparam int         CFG_ENABLE          = 0;
  localparam int         CFG_PALETTE         = 1;
  localparam int         CFG_NEAREST         = 2;
  localparam int         CFG_SHIFT_EDGE      = 4;
  localparam int         CFG_DE_POL          = 5;
  localparam int         CFG_LINE_POL        = 6;
  localparam int         CFG_FRAME_POL       = 7;
  localparam logic [7:0] CFG_WRITE_MASK      = 8'hf7;
  localparam logic [7:0] VCO_WRITE_MASK      = 8'h7f;
  localparam int         BUF_DEPTH           = 2;
  typedef enum logic [1:0] {
    BPP_1 = 2'h0,
    BPP_2 = 2'h1,
    BPP_4 = 2'h2,
    BPP_R = 2'h3
  } tpc_bpp_type;
endpackage

/* tpc_skid_buffer.sv */
// tpc_skid_buffer: two-entry flip-flop buffer with valid/ready on both sides
// assumes: synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tpc_skid_buffer #(
  parameter int W = 9
) (
  input  wire logic   i_clk,
  input  wire logic   i_srst,
  tpc_buf_if.dst      in_if,
  output var  logic   o_valid,
  output var  logic [W-1:0] o_data,
  input  wire logic   i_ready
);
  logic [W-1:0] mem_q [tpc_pkg::BUF_DEPTH];
  logic [W-1:0] mem_d [tpc_pkg::BUF_DEPTH];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  assign in_if.ready = (cnt_q != 2'h2);
  assign o_valid     = (cnt_q != 2'h0);
  assign o_data      = mem_q[rp_q];
  assign push        = in_if.valid && in_if.ready;
  assign pop         = o_valid && i_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_if.data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
      for (int i = 0; i < tpc_pkg::BUF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule // tpc_skid_buffer
`default_nettype wire
